// >>> core/adci_pkg.sv
// Purpose: shared constants and types for the adc serial register port
// Assumes: 25 MHz system clock on both ends
// Notes:   register pointer values and config field layout live here
package adci_pkg;
  // system clock
  localparam int CLK_PERIOD_NS = 40;
  // register pointer values
  localparam logic [7:0] PTR_RESULT = 8'h00;
  localparam logic [7:0] PTR_CONFIG = 8'h01;
  // configuration register layout and reset value
  localparam logic [15:0] CFG_RESET = 16'h8583;
  localparam int CFG_START_BIT = 15;
  localparam int CFG_SINGLE_BIT = 8;
  localparam int CFG_RATE_LSB = 5;
  localparam int CFG_RATE_W = 3;
  // result saturation codes
  localparam logic [15:0] RES_MAX = 16'h7FFF;
  localparam logic [15:0] RES_MIN = 16'h8000;
  localparam int SAMPLE_W = 18;
  // conversion period at fastest rate, doubled per lower rate step
  localparam int CONV_BASE_CYC = 29070;
  // serial clock generated by the host end
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  // host register byte addresses
  localparam logic [4:0] AVS_CTRL = 5'h00;
  localparam logic [4:0] AVS_SLAVE = 5'h04;
  localparam logic [4:0] AVS_TXDATA = 5'h08;
  localparam logic [4:0] AVS_RXDATA = 5'h0C;
  localparam logic [4:0] AVS_STATUS = 5'h10;
  // host control fields
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_RW_BIT = 1;
  localparam int CTRL_NB_LSB = 2;
  // device end protocol states
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_AACK = 3'b010,
    D_WRB  = 3'b011,
    D_WACK = 3'b100,
    D_RDB  = 3'b101,
    D_RACK = 3'b110
  } adci_dst_t;
  // host end sequencer states
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BIT   = 2'b10,
    H_STOP  = 2'b11
  } adci_hst_t;
endpackage

// >>> core/adci_if.sv
// Purpose: two-wire link joining host end and device end
// Assumes: open-drain lines with pull-ups, enable high pulls low
// Notes:   only the host has an enable on the clock line
`timescale 1ns/1ps
`default_nettype none
interface adci_if;
  logic scl_oe_host;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic scl;
  logic sda;
  // wired-and of the open-drain drivers
  assign scl = ~scl_oe_host;
  assign sda = ~(sda_oe_host | sda_oe_dev);
  modport host (output scl_oe_host, output sda_oe_host, input sda);
  modport dev (output sda_oe_dev, input scl, input sda);
endinterface
`default_nettype wire

// >>> core/adci_dev.sv
// Purpose: adc register port, serial slave plus conversion sequencer
// Assumes: i_sample is the analog core output on the same clock
// Notes:   scl and sda pass two flip-flops before any use
//
// Overview of operation
// [R1] single-shot does one conversion into result
// [R2] single-shot idles in shutdown after conversion
// [R3] continuous restarts conversion when previous ends
// [R4] continuous period follows programmed data rate
// [R5] result read anytime returns latest conversion
// [R6] master drives the serial clock
// [R7] device never drives the clock line
// [R8] master opens write with address, low rw
// [R9] first write byte after address is pointer
// [R10] bytes three and four stored msb first
// [R11] master frames transactions with start and stop
// [R12] pointer one selects configuration register
// [R13] pointer zero selects result, set by write
// [R14] read returns sixteen bits, msb first
// [R15] master sends config upper byte first
// [R16] results are 16-bit two's complement
// [R17] results saturate at 7FFF and 8000
// [R18] pointer kept across stop
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module adci_dev #(
  parameter int unsigned P_CONV_BASE_CYC = adci_pkg::CONV_BASE_CYC
) (
  input  wire logic                                i_clk,
  input  wire logic                                i_rst_n,
  input  wire logic [6:0]                          i_slave_addr,
  input  wire logic signed [adci_pkg::SAMPLE_W-1:0] i_sample,
  output logic      [15:0]                         o_result,
  output logic                                     o_converting,
  output logic                                     o_shutdown,
  adci_if.dev                                      bus
);

  typedef struct packed {
    adci_pkg::adci_dst_t st;
    logic [1:0]          scl_s;
    logic [1:0]          sda_s;
    logic                scl_q;
    logic                sda_q;
    logic [7:0]          sh;
    logic [3:0]          bitc;
    logic [1:0]          bytec;
    logic                rw;
    logic [7:0]          ptr;
    logic [7:0]          msb;
    logic [15:0]         tx;
    logic                sda_oe;
    logic [15:0]         cfg;
    logic [15:0]         result;
    logic                busy;
    logic [23:0]         timer;
  } adci_dstate_t;

  localparam adci_dstate_t RST_VAL = '{
    st:      adci_pkg::D_IDLE,
    scl_s:   2'b11,
    sda_s:   2'b11,
    scl_q:   1'b1,
    sda_q:   1'b1,
    cfg:     adci_pkg::CFG_RESET,
    default: '0
  };

  adci_dstate_t r;
  adci_dstate_t n;

  // conversion length in cycles; each lower rate code doubles it
  function automatic logic [23:0] conv_cycles(input logic [adci_pkg::CFG_RATE_W-1:0] rate);
    logic [2:0] sh_amt;
    sh_amt = 3'h7 - rate;
    conv_cycles = 24'(P_CONV_BASE_CYC) << sh_amt; // [R4]
  endfunction

  // clip the wide core sample into the 16-bit code space
  function automatic logic [15:0] saturate(input logic signed [adci_pkg::SAMPLE_W-1:0] s);
    if (s > $signed(18'h07FFF)) begin
      saturate = adci_pkg::RES_MAX; // [R17]
    end else if (s < $signed(18'h38000)) begin
      saturate = adci_pkg::RES_MIN; // [R17]
    end else begin
      saturate = s[15:0]; // [R16]
    end
  endfunction

  // register view selected by the pointer
  function automatic logic [15:0] sel_reg(input adci_dstate_t s);
    if (s.ptr == adci_pkg::PTR_RESULT) begin
      sel_reg = s.result; // [R13] [R5]
    end else if (s.ptr == adci_pkg::PTR_CONFIG) begin
      sel_reg = {~s.busy, s.cfg[14:0]}; // [R12]
    end else begin
      sel_reg = 16'h0000;
    end
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic start_req;
  logic [15:0] rd_val;

  // line edges and bus conditions, all from second sync stage on
  assign scl_rise = r.scl_s[1] & ~r.scl_q;
  assign scl_fall = ~r.scl_s[1] & r.scl_q;
  assign start_cond = r.scl_s[1] & r.scl_q & r.sda_q & ~r.sda_s[1];
  assign stop_cond = r.scl_s[1] & r.scl_q & ~r.sda_q & r.sda_s[1];
  assign rd_val = sel_reg(r);

  // next-state logic: serial protocol then conversion sequencer
  always_comb begin
    n = r;
    start_req = 1'b0;
    n.scl_s = {r.scl_s[0], bus.scl};
    n.sda_s = {r.sda_s[0], bus.sda};
    n.scl_q = r.scl_s[1];
    n.sda_q = r.sda_s[1];
    // start may repeat mid-transaction; it always resyncs the frame
    if (start_cond) begin
      n.st = adci_pkg::D_ADDR;
      n.bitc = 4'h0;
      n.bytec = 2'h0;
      n.sda_oe = 1'b0;
    end else if (stop_cond) begin
      n.st = adci_pkg::D_IDLE; // pointer left alone [R18]
      n.sda_oe = 1'b0;
    end else begin
      case (r.st)
        adci_pkg::D_ADDR: begin
          if (scl_rise) begin
            n.sh = {r.sh[6:0], r.sda_s[1]};
            n.bitc = r.bitc + 4'h1;
          end else if (scl_fall && r.bitc == 4'h8) begin
            if (r.sh[7:1] == i_slave_addr) begin
              n.sda_oe = 1'b1;
              n.rw = r.sh[0]; // [R8]
              n.st = adci_pkg::D_AACK;
            end else begin
              n.st = adci_pkg::D_IDLE;
            end
          end
        end
        adci_pkg::D_AACK: begin
          if (scl_fall) begin
            n.bitc = 4'h0;
            if (r.rw) begin
              n.tx = rd_val; // [R14]
              n.sda_oe = ~rd_val[15];
              n.st = adci_pkg::D_RDB;
            end else begin
              n.sda_oe = 1'b0;
              n.st = adci_pkg::D_WRB;
            end
          end
        end
        adci_pkg::D_WRB: begin
          if (scl_rise) begin
            n.sh = {r.sh[6:0], r.sda_s[1]};
            n.bitc = r.bitc + 4'h1;
          end else if (scl_fall && r.bitc == 4'h8) begin
            n.sda_oe = 1'b1;
            n.st = adci_pkg::D_WACK;
            if (r.bytec != 2'h3) begin
              n.bytec = r.bytec + 2'h1;
            end
            case (r.bytec)
              2'h0: n.ptr = r.sh; // [R9] [R13]
              2'h1: n.msb = r.sh; // [R10]
              2'h2: begin
                // result is read-only, only config takes data [R12]
                if (r.ptr == adci_pkg::PTR_CONFIG) begin
                  n.cfg = {1'b0, r.msb[6:0], r.sh}; // [R10]
                  start_req = r.msb[7];
                end
              end
              default: ;
            endcase
          end
        end
        adci_pkg::D_WACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.bitc = 4'h0;
            n.st = adci_pkg::D_WRB;
          end
        end
        adci_pkg::D_RDB: begin
          // data only changes while scl is low; clock line is never touched [R7]
          if (scl_rise) begin
            n.bitc = r.bitc + 4'h1;
          end else if (scl_fall) begin
            n.tx = {r.tx[14:0], 1'b0};
            if (r.bitc == 4'h8) begin
              n.sda_oe = 1'b0;
              n.st = adci_pkg::D_RACK;
            end else begin
              n.sda_oe = ~r.tx[14]; // [R14]
            end
          end
        end
        adci_pkg::D_RACK: begin
          if (scl_rise && r.sda_s[1]) begin
            n.st = adci_pkg::D_IDLE; // master nack ends the read
          end else if (scl_fall) begin
            n.bitc = 4'h0;
            n.sda_oe = ~r.tx[15]; // lsb byte follows msb [R14]
            n.st = adci_pkg::D_RDB;
          end
        end
        default: n.st = adci_pkg::D_IDLE;
      endcase
    end
    // conversion sequencer
    if (r.busy) begin
      if (r.timer == 24'h000000) begin
        n.result = saturate(i_sample); // [R1] [R5]
        if (r.cfg[adci_pkg::CFG_SINGLE_BIT]) begin
          n.busy = 1'b0; // [R2]
        end else begin
          n.timer = conv_cycles(n.cfg[adci_pkg::CFG_RATE_LSB +: adci_pkg::CFG_RATE_W]) - 24'h1; // [R3] [R4]
        end
      end else begin
        n.timer = r.timer - 24'h1;
      end
    end else if ((start_req && n.cfg[adci_pkg::CFG_SINGLE_BIT])
                 || !n.cfg[adci_pkg::CFG_SINGLE_BIT]) begin
      // a start request while busy is dropped, one result per request [R1]
      n.busy = 1'b1; // [R3]
      n.timer = conv_cycles(n.cfg[adci_pkg::CFG_RATE_LSB +: adci_pkg::CFG_RATE_W]) - 24'h1;
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= RST_VAL;
    end else begin
      r <= n;
    end
  end

  // outputs straight from state
  assign o_result = r.result;
  assign o_converting = r.busy;
  assign o_shutdown = ~r.busy; // [R2]
  assign bus.sda_oe_dev = r.sda_oe;

endmodule
`default_nettype wire

// >>> core/adci_host.sv
// Purpose: serial master driven by software over avalon-mm
// Assumes: single master on the link, slave never stretches the clock
// Notes:   one transaction: address byte plus up to three data bytes
`timescale 1ns/1ps
`default_nettype none
module adci_host (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_busy,
  adci_if.host             bus
);

  // last divider count of a quarter serial clock period, in system clocks
  localparam logic [4:0] QTR_LAST = 5'(adci_pkg::SCL_QTR_CYC - 1);

  typedef struct packed {
    adci_pkg::adci_hst_t st;
    logic [1:0]          sda_s;
    logic [4:0]          qcnt;
    logic [1:0]          ph;
    logic [3:0]          bitc;
    logic [1:0]          bytec;
    logic [1:0]          nb;
    logic                rw;
    logic [6:0]          slave;
    logic [23:0]         txd;
    logic [23:0]         rxd;
    logic [7:0]          sh;
    logic                scl_oe;
    logic                sda_oe;
    logic                nack;
    logic                ack;
    logic [31:0]         rdata;
  } adci_hstate_t;

  localparam adci_hstate_t RST_VAL = '{
    st:      adci_pkg::H_IDLE,
    sda_s:   2'b11,
    default: '0
  };

  adci_hstate_t r;
  adci_hstate_t n;

  logic req;
  logic wr_en;
  logic tick;
  logic go;
  logic rx_byte;

  // data byte k of the transmit word, byte 0 leaves first
  function automatic logic [7:0] tx_byte(input logic [23:0] d, input logic [1:0] k);
    case (k)
      2'h0:    tx_byte = d[7:0];
      2'h1:    tx_byte = d[15:8];
      default: tx_byte = d[23:16];
    endcase
  endfunction

  // one wait state: reads are captured in flops before waitrequest drops
  assign req = i_avs_read | i_avs_write;
  assign wr_en = i_avs_write & r.ack;
  assign tick = (r.qcnt == QTR_LAST);
  assign go = wr_en & (i_avs_address == adci_pkg::AVS_CTRL) & i_avs_writedata[adci_pkg::CTRL_GO_BIT]
              & (r.st == adci_pkg::H_IDLE);
  assign rx_byte = r.rw & (r.bytec != 2'h0);

  // next-state logic: register file then bit sequencer
  always_comb begin
    n = r;
    n.sda_s = {r.sda_s[0], bus.sda};
    n.ack = req & ~r.ack;
    if (i_avs_read && !r.ack) begin
      case (i_avs_address)
        adci_pkg::AVS_CTRL:   n.rdata = {28'h0000000, r.nb, r.rw, 1'b0};
        adci_pkg::AVS_SLAVE:  n.rdata = {25'h0000000, r.slave};
        adci_pkg::AVS_TXDATA: n.rdata = {8'h00, r.txd};
        adci_pkg::AVS_RXDATA: n.rdata = {8'h00, r.rxd};
        adci_pkg::AVS_STATUS: n.rdata = {30'h00000000, r.nack, r.st != adci_pkg::H_IDLE};
        default:              n.rdata = 32'h00000000;
      endcase
    end
    if (wr_en) begin
      case (i_avs_address)
        adci_pkg::AVS_SLAVE:  n.slave = i_avs_writedata[6:0];
        adci_pkg::AVS_TXDATA: n.txd = i_avs_writedata[23:0];
        default: ;
      endcase
    end
    // divider gives one tick per quarter period while a frame runs
    if (r.st != adci_pkg::H_IDLE) begin
      n.qcnt = tick ? 5'h00 : r.qcnt + 5'h01;
    end
    case (r.st)
      adci_pkg::H_IDLE: begin
        if (go) begin
          n.st = adci_pkg::H_START;
          n.qcnt = 5'h00;
          n.ph = 2'h0;
          n.bitc = 4'h0;
          n.bytec = 2'h0;
          n.rw = i_avs_writedata[adci_pkg::CTRL_RW_BIT];
          n.nb = i_avs_writedata[adci_pkg::CTRL_NB_LSB +: 2];
          n.sh = {r.slave, i_avs_writedata[adci_pkg::CTRL_RW_BIT]}; // [R8]
          n.nack = 1'b0;
          n.rxd = 24'h000000;
          n.sda_oe = 1'b1; // start: sda falls while scl is high [R11]
        end
      end
      adci_pkg::H_START: begin
        if (tick) begin
          if (r.ph == 2'h1) begin
            n.scl_oe = 1'b1; // [R6]
            n.ph = 2'h0;
            n.st = adci_pkg::H_BIT;
          end else begin
            n.ph = r.ph + 2'h1;
          end
        end
      end
      adci_pkg::H_BIT: begin
        if (tick) begin
          n.ph = r.ph + 2'h1;
          case (r.ph)
            2'h0: begin
              // data moves only in the low half of the clock
              if (r.bitc == 4'h8) begin
                n.sda_oe = rx_byte ? (r.bytec != r.nb) : 1'b0;
              end else begin
                n.sda_oe = rx_byte ? 1'b0 : ~r.sh[7]; // [R15]
              end
            end
            2'h1: n.scl_oe = 1'b0; // [R6]
            2'h2: begin
              if (r.bitc != 4'h8) begin
                n.sh = {r.sh[6:0], r.sda_s[1]};
              end else if (!rx_byte) begin
                n.nack = r.nack | r.sda_s[1];
              end
            end
            default: begin
              n.scl_oe = 1'b1;
              if (r.bitc == 4'h8) begin
                n.bitc = 4'h0;
                n.bytec = r.bytec + 2'h1;
                if (rx_byte) begin
                  n.rxd = {r.rxd[15:0], r.sh};
                end
                if (r.bytec == r.nb) begin
                  n.st = adci_pkg::H_STOP;
                end else begin
                  n.sh = tx_byte(r.txd, r.bytec);
                end
              end else begin
                n.bitc = r.bitc + 4'h1;
              end
            end
          endcase
        end
      end
      adci_pkg::H_STOP: begin
        if (tick) begin
          n.ph = r.ph + 2'h1;
          case (r.ph)
            2'h0:    n.sda_oe = 1'b1;
            2'h1:    n.scl_oe = 1'b0;
            2'h2:    n.sda_oe = 1'b0; // stop: sda rises while scl is high [R11]
            default: n.st = adci_pkg::H_IDLE;
          endcase
        end
      end
      default: n.st = adci_pkg::H_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= RST_VAL;
    end else begin
      r <= n;
    end
  end

  // outputs straight from state; waitrequest also takes the read and write inputs
  assign o_avs_waitrequest = req & ~r.ack;
  assign o_avs_readdata = r.rdata;
  assign o_busy = (r.st != adci_pkg::H_IDLE);
  assign bus.scl_oe_host = r.scl_oe;
  assign bus.sda_oe_host = r.sda_oe;

endmodule
`default_nettype wire

// >>> tb/adci_assertions.sv
// Purpose: link protocol checks between host end and device end
// Assumes: one clock samples both lines
// Notes:   tracker counts scl rises from each start
`timescale 1ns/1ps
`default_nettype none
module adci_assertions (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic scl_oe_host,
  input wire logic sda_oe_host,
  input wire logic sda_oe_dev,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       busy_q;
  logic       rd_q;
  logic [3:0] bit_q;
  logic [2:0] byte_q;
  logic       start_ev;
  logic       stop_ev;
  logic       rise;
  // edges against the previous sample
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev  = scl && scl_q && !sda_q && sda;
  assign rise     = scl && !scl_q;
  // frame tracker; clears on every start so a repeated start is safe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_q  <= 1'h1;
      sda_q  <= 1'h1;
      busy_q <= 1'h0;
      rd_q   <= 1'h0;
      bit_q  <= 4'h0;
      byte_q <= 3'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev) begin
        busy_q <= 1'h1;
        rd_q   <= 1'h0;
        bit_q  <= 4'h0;
        byte_q <= 3'h0;
      end else if (stop_ev) begin
        busy_q <= 1'h0;
      end else if (rise) begin
        bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
        if (bit_q == 4'h8)
          byte_q <= byte_q + 3'h1;
        if (byte_q == 3'h0 && bit_q == 4'h7)
          rd_q <= sda;
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence start_hold_s;
    (scl && !sda)[*8];
  endsequence
  sequence bus_free_s;
    (scl && sda)[*8];
  endsequence
  sequence ack_slot_s;
    rise && bit_q == 4'h8;
  endsequence
  scl_src_a: assert property (scl == !scl_oe_host)
    else $error("scl differs from host enable");
  dev_setup_a: assert property ($changed(sda_oe_dev) |-> !scl)
    else $error("device moved sda with scl high");
  start_hold_a: assert property (start_ev |-> start_hold_s)
    else $error("start not held");
  bus_free_a: assert property (stop_ev |-> bus_free_s)
    else $error("bus not free after stop");
  addr_quiet_a: assert property (busy_q && byte_q == 3'h0 && bit_q != 4'h8 && scl |-> !sda_oe_dev)
    else $error("device drove address byte");
  host_ack_a: assert property (ack_slot_s ##0 (byte_q == 3'h0 || !rd_q) |-> !sda_oe_host)
    else $error("host drove device ack slot");
  dev_ack_a: assert property (ack_slot_s ##0 (byte_q != 3'h0 && rd_q) |-> !sda_oe_dev)
    else $error("device drove host ack slot");
  read_len_a: assert property (stop_ev && busy_q && rd_q |-> byte_q == 3'h3)
    else $error("read frame not two data bytes");
  write_len_a: assert property (stop_ev && busy_q && !rd_q |-> byte_q == 3'h2 || byte_q == 3'h4)
    else $error("write frame of wrong length");
endmodule
`default_nettype wire

// >>> tb/adci_tb.sv
// Purpose: host end driving device end over the link
// Assumes: txdata byte 0 goes out first after the address
// Notes:   conversion base shortened to keep the run brief
`timescale 1ns/1ps
`default_nettype none
module adci_tb;
  logic        clk;
  logic        rst_n;
  logic [4:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wreq;
  logic        busy;
  logic        conv;
  logic        shut;
  logic [17:0] sample;
  logic [16:0] lfsr;
  logic [15:0] val;
  logic [15:0] exp_q[$];
  int          t1;
  int          t2;
  int          err_count;
  int          num_checks;
  adci_if link ();
  adci_host i_adci_host (.i_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .o_busy(busy), .bus(link));
  adci_dev #(.P_CONV_BASE_CYC(300)) i_adci_dev (.i_clk(clk), .i_rst_n(rst_n), .i_slave_addr(7'h48),
    .i_sample(sample), .o_result(), .o_converting(conv), .o_shutdown(shut), .bus(link));
  adci_assertions i_adci_assertions (.i_clk(clk), .i_rst_n(rst_n), .scl_oe_host(link.scl_oe_host),
    .sda_oe_host(link.sda_oe_host), .sda_oe_dev(link.sda_oe_dev), .scl(link.scl), .sda(link.sda));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    num_checks++;
    if (seen !== expv) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one avalon cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'h0 && n < 200);
    wr <= 1'h0;
    rd <= 1'h0;
  endtask
  task automatic frame(input logic r, input logic [1:0] nb, input logic [23:0] d);
    int n;
    bus(1'h1, adci_pkg::AVS_SLAVE, 32'h0000_0048);
    bus(1'h1, adci_pkg::AVS_TXDATA, {8'h00, d});
    bus(1'h1, adci_pkg::AVS_CTRL, {28'h0, nb, r, 1'h1});
    repeat (3) @(posedge clk);
    n = 0;
    while (busy !== 1'h0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic write_cfg(input logic [15:0] c);
    frame(1'h0, 2'h3, {c[7:0], c[15:8], adci_pkg::PTR_CONFIG});
  endtask
  task automatic read_reg(input logic set_ptr, input logic [7:0] ptr, input logic [15:0] expv);
    if (set_ptr)
      frame(1'h0, 2'h1, {16'h0000, ptr});
    frame(1'h1, 2'h2, 24'h000000);
    exp_q.push_back(expv);
    bus(1'h0, adci_pkg::AVS_RXDATA, 32'h0000_0000);
  endtask
  // cycles until the next finished conversion; busy stays high in continuous mode
  task automatic wait_conv(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(i_adci_dev.r.busy === 1'h1 && i_adci_dev.r.timer === 24'h0) && n < 9000);
    @(posedge clk);
  endtask
  // read data checked at the edge where the read completes
  always @(posedge clk) begin
    if (rd && wreq === 1'h0 && addr == adci_pkg::AVS_RXDATA && exp_q.size() > 0)
      check(rdata[15:0], exp_q.pop_front());
  end
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    $display("mismatch at %0t: timeout", $time);
    results();
  end
  initial begin
    {rst_n, addr, rd, wr, wdata, sample} = '0;
    lfsr = 17'h17450;
    err_count = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    // single shots: two random codes, then both clip points
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      val = (i == 2) ? adci_pkg::RES_MAX : (i == 3) ? adci_pkg::RES_MIN : lfsr[15:0];
      sample <= (i == 2) ? 18'h1FFFF : (i == 3) ? 18'h20000 : {{2{val[15]}}, val};
      write_cfg(16'h8583);
      wait_conv(t1);
      check({15'h0, shut}, 16'h0001);
      read_reg(1'h1, adci_pkg::PTR_RESULT, val);
    end
    read_reg(1'h1, adci_pkg::PTR_CONFIG, 16'h8583);
    // continuous: new samples land with no further request
    write_cfg(16'h8483);
    wait_conv(t1);
    wait_conv(t1);
    check({15'h0, shut}, 16'h0000);
    lfsr = lfsr_next(lfsr);
    val = lfsr[15:0];
    sample <= {{2{val[15]}}, val};
    wait_conv(t1);
    wait_conv(t1);
    read_reg(1'h1, adci_pkg::PTR_RESULT, val);
    read_reg(1'h0, adci_pkg::PTR_RESULT, val);
    write_cfg(16'h8463);
    wait_conv(t2);
    wait_conv(t2);
    check({15'h0, (t2 - 2 * t1) inside {[-8:8]}}, 16'h0001);
    results();
  end
endmodule
`default_nettype wire
